/* bia_pkg.sv */
package bia_pkg;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam int unsigned BIA_AW = 12;
  localparam int unsigned BIA_DW = 32;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [BIA_AW-1:0] addr;
    logic [BIA_DW-1:0] wdata;
  } bia_req_t;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [BIA_AW-1:0] BIA_OFS_GLOBAL_EN   = 12'h000;
  localparam logic [BIA_AW-1:0] BIA_OFS_GATE_CLR    = 12'h004;
  localparam logic [BIA_AW-1:0] BIA_OFS_SUMMARY     = 12'h008;
  localparam logic [BIA_AW-1:0] BIA_OFS_EDGE_EN     = 12'h00c;
  localparam logic [BIA_AW-1:0] BIA_OFS_EDGE_CLR    = 12'h010;
  localparam logic [BIA_AW-1:0] BIA_OFS_EDGE_FLAGS  = 12'h014;
  localparam logic [BIA_AW-1:0] BIA_OFS_CHG_EN      = 12'h018;
  localparam logic [BIA_AW-1:0] BIA_OFS_CHG_MASK    = 12'h01c;
  localparam logic [BIA_AW-1:0] BIA_OFS_CHG_CLR     = 12'h020;
  localparam logic [BIA_AW-1:0] BIA_OFS_CHG_FLAG    = 12'h024;
  localparam logic [BIA_AW-1:0] BIA_OFS_CNT_EN      = 12'h028;
  localparam logic [BIA_AW-1:0] BIA_OFS_CNT_CLR     = 12'h02c;
  localparam logic [BIA_AW-1:0] BIA_OFS_CNT_FLAGS   = 12'h030;
  localparam logic [BIA_AW-1:0] BIA_OFS_TMR_EN      = 12'h034;
  localparam logic [BIA_AW-1:0] BIA_OFS_TMR_CLR     = 12'h038;
  localparam logic [BIA_AW-1:0] BIA_OFS_TMR_FLAGS   = 12'h03c;
  localparam logic [BIA_AW-1:0] BIA_OFS_CAP_EN      = 12'h040;
  localparam logic [BIA_AW-1:0] BIA_OFS_CAP_CLR     = 12'h044;
  localparam logic [BIA_AW-1:0] BIA_OFS_CAP_FLAGS   = 12'h048;
  localparam logic [BIA_AW-1:0] BIA_OFS_GATE_STAT   = 12'h04c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BIA_BIT_EN        = 0;
  localparam int unsigned BIA_SUM_EDGE      = 0;
  localparam int unsigned BIA_SUM_CHANGE    = 1;
  localparam int unsigned BIA_SUM_COUNTER   = 4;
  localparam int unsigned BIA_SUM_TIMER     = 5;
  localparam int unsigned BIA_SUM_COMPARE   = 6;
  localparam int unsigned BIA_MASK_MAX      = 16;
  localparam int unsigned BIA_UNIT_MAX      = 2;
  localparam logic [BIA_DW-1:0] BIA_RST_WORD = 32'h0000_0000;

endpackage

/* bia_top.sv */
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
//
// Contract
// - Nonzero 32-bit summary sets the gate
// - Host sees gate only with global enable
// - Line blocked until gate re-armed
// - Serviced, re-enabled source clears its summary bit
// - Gate clear write clears gate, not summary
// - Global enable bit 0, resets locked
// - Summary bit 6 from output-compare units and enabled capture units
// - Summary bit 5 from timers
// - Summary bit 4 from counters
// - Summary bit 1 from input change
// - Summary bit 0 from input rising edge
// - Edge source routed through edge flags
// - Per-input edge enable mask, 16 bits
// - Read-only edge flags latch rising edges
// - Write one clears matching edge flag
// - Edge clear bits self-clear
// - Change interrupt enable bit, default 0
// - Per-input change enable mask, default 0
// - Change flag reads one after change
// - Change clear write resets flag, self-clears
// - Per-unit flag, enable, clear for counters, timers, capture
//
module bia_top
  import bia_pkg::*;
#(
  parameter int unsigned N_INPUTS   = 16,
  parameter int unsigned N_COUNTERS = 16,
  parameter int unsigned N_TIMERS   = 2,
  parameter int unsigned N_CAPTURE  = 2,
  parameter int unsigned N_COMPARE  = 2
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire bia_req_t              reg_req_in,
  output logic [BIA_DW-1:0]          reg_rdata_out,
  input  wire logic [N_INPUTS-1:0]   iso_in,
  input  wire logic [N_COUNTERS-1:0] counter_irq_flags_in,
  input  wire logic [N_TIMERS-1:0]   timer_irq_flags_in,
  input  wire logic [N_CAPTURE-1:0]  capture_irq_flags_in,
  input  wire logic [N_COMPARE-1:0]  compare_irq_flags_in,
  output logic [N_COUNTERS-1:0]      counter_irq_clears_out,
  output logic [N_TIMERS-1:0]        timer_irq_clears_out,
  output logic [N_CAPTURE-1:0]       capture_irq_clears_out,
  output logic                       host_irq_out
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (N_INPUTS < 1 || N_INPUTS > BIA_MASK_MAX || N_COUNTERS < 1 || N_COUNTERS > BIA_MASK_MAX) begin : g_bad_width
    $error("bia_top: input or counter count out of range");
  end
  if (N_TIMERS < 1 || N_TIMERS > BIA_UNIT_MAX || N_CAPTURE < 1 || N_CAPTURE > BIA_UNIT_MAX ||
      N_COMPARE < 1) begin : g_bad_units
    $error("bia_top: unit count out of range");
  end
  if (BIA_SUM_COMPARE >= BIA_DW || N_INPUTS > BIA_DW) begin : g_bad_map
    $error("bia_top: summary map wider than data word");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire logic wr_global_en = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_GLOBAL_EN);
  wire logic wr_gate_clr  = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_GATE_CLR);
  wire logic wr_edge_en   = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_EDGE_EN);
  wire logic wr_edge_clr  = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_EDGE_CLR);
  wire logic wr_chg_en    = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CHG_EN);
  wire logic wr_chg_mask  = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CHG_MASK);
  wire logic wr_chg_clr   = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CHG_CLR);
  wire logic wr_cnt_en    = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CNT_EN);
  wire logic wr_cnt_clr   = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CNT_CLR);
  wire logic wr_tmr_en    = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_TMR_EN);
  wire logic wr_tmr_clr   = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_TMR_CLR);
  wire logic wr_cap_en    = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CAP_EN);
  wire logic wr_cap_clr   = reg_req_in.wr && (reg_req_in.addr == BIA_OFS_CAP_CLR);

  // Write data fields
  wire logic                  wd_bit      = reg_req_in.wdata[BIA_BIT_EN];
  wire logic [N_INPUTS-1:0]   wd_inputs   = reg_req_in.wdata[N_INPUTS-1:0];
  wire logic [N_COUNTERS-1:0] wd_counters = reg_req_in.wdata[N_COUNTERS-1:0];
  wire logic [N_TIMERS-1:0]   wd_timers   = reg_req_in.wdata[N_TIMERS-1:0];
  wire logic [N_CAPTURE-1:0]  wd_capture  = reg_req_in.wdata[N_CAPTURE-1:0];

  // Read hits
  wire logic hit_global_en  = (reg_req_in.addr == BIA_OFS_GLOBAL_EN);
  wire logic hit_summary    = (reg_req_in.addr == BIA_OFS_SUMMARY);
  wire logic hit_edge_en    = (reg_req_in.addr == BIA_OFS_EDGE_EN);
  wire logic hit_edge_flags = (reg_req_in.addr == BIA_OFS_EDGE_FLAGS);
  wire logic hit_chg_en     = (reg_req_in.addr == BIA_OFS_CHG_EN);
  wire logic hit_chg_mask   = (reg_req_in.addr == BIA_OFS_CHG_MASK);
  wire logic hit_chg_flag   = (reg_req_in.addr == BIA_OFS_CHG_FLAG);
  wire logic hit_cnt_en     = (reg_req_in.addr == BIA_OFS_CNT_EN);
  wire logic hit_cnt_flags  = (reg_req_in.addr == BIA_OFS_CNT_FLAGS);
  wire logic hit_tmr_en     = (reg_req_in.addr == BIA_OFS_TMR_EN);
  wire logic hit_tmr_flags  = (reg_req_in.addr == BIA_OFS_TMR_FLAGS);
  wire logic hit_cap_en     = (reg_req_in.addr == BIA_OFS_CAP_EN);
  wire logic hit_cap_flags  = (reg_req_in.addr == BIA_OFS_CAP_FLAGS);
  wire logic hit_gate_stat  = (reg_req_in.addr == BIA_OFS_GATE_STAT);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic                  global_en_r;
  logic                  gate_r;
  logic [BIA_DW-1:0]     summary_r;
  logic [N_INPUTS-1:0]   edge_irq_enable_mask_r;
  logic [N_INPUTS-1:0]   edge_irq_flags_r;
  logic                  change_irq_enable_r;
  logic [N_INPUTS-1:0]   change_input_enable_mask_r;
  logic                  change_irq_flag_r;
  logic [N_COUNTERS-1:0] counter_irq_enables_r;
  logic [N_TIMERS-1:0]   timer_irq_enables_r;
  logic [N_CAPTURE-1:0]  capture_irq_enables_r;
  logic [N_INPUTS-1:0]   iso_meta_r;
  logic [N_INPUTS-1:0]   iso_sync_r;
  logic [N_INPUTS-1:0]   iso_prev_r;
  logic [BIA_DW-1:0]     rdata_r;

  // ---------------------------------------------------------------
  // Input synchroniser and detectors
  // ---------------------------------------------------------------
  // Two stages before any logic reads the pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      iso_meta_r <= '0;
      iso_sync_r <= '0;
    end else begin
      iso_meta_r <= iso_in;
      iso_sync_r <= iso_meta_r;
    end
  end

  // Previous sample for edge and change compare
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      iso_prev_r <= '0;
    end else begin
      iso_prev_r <= iso_sync_r;
    end
  end

  wire logic [N_INPUTS-1:0] edge_clr = wr_edge_clr ? wd_inputs : '0;
  wire logic [N_INPUTS-1:0] edge_rise;
  wire logic [N_INPUTS-1:0] edge_flags_nxt;

  // Per-input edge detect; a new edge beats a clear in the same cycle
  for (genvar gi = 0; gi < N_INPUTS; gi++) begin : g_edge
    assign edge_rise[gi]      = iso_sync_r[gi] && !iso_prev_r[gi] && edge_irq_enable_mask_r[gi];
    assign edge_flags_nxt[gi] = edge_rise[gi] || (edge_irq_flags_r[gi] && !edge_clr[gi]);
  end

  // ---------------------------------------------------------------
  // Change detect
  // ---------------------------------------------------------------
  // Any enabled input toggling counts as a change
  wire logic chg_hit = change_irq_enable_r &&
                       |((iso_sync_r ^ iso_prev_r) & change_input_enable_mask_r);
  wire logic chg_clr = wr_chg_clr && reg_req_in.wdata[BIA_BIT_EN];
  wire logic change_flag_nxt = chg_hit || (change_irq_flag_r && !chg_clr);

  // ---------------------------------------------------------------
  // Summary and gate
  // ---------------------------------------------------------------
  logic [BIA_DW-1:0] live;
  always_comb begin
    live = BIA_RST_WORD;
    live[BIA_SUM_EDGE]    = |edge_irq_flags_r;
    live[BIA_SUM_CHANGE]  = change_irq_flag_r;
    live[BIA_SUM_COUNTER] = |(counter_irq_flags_in & counter_irq_enables_r);
    live[BIA_SUM_TIMER]   = |(timer_irq_flags_in & timer_irq_enables_r);
    live[BIA_SUM_COMPARE] = |compare_irq_flags_in |
                            |(capture_irq_flags_in & capture_irq_enables_r);
  end

  wire logic gate_clr    = wr_gate_clr && wd_bit;
  wire logic summary_any = |summary_r;
  // Live sources win over the clear; a serviced source drops its bit
  wire logic [BIA_DW-1:0] summary_nxt = live | (summary_r & live & {BIA_DW{!gate_clr}});
  wire logic gate_nxt = summary_any || (gate_r && !gate_clr);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      summary_r <= BIA_RST_WORD;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Gate and host line
  // ---------------------------------------------------------------
  // Gate holds until re-armed; a nonzero summary sets it again
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // Level output, never a pulse
  assign host_irq_out = gate_r && global_en_r;

  // ---------------------------------------------------------------
  // Software registers and clear pulses
  // ---------------------------------------------------------------
  // Enables and masks; upper bits of a write are ignored
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      global_en_r <= 1'b0;
    end else if (wr_global_en) begin
      global_en_r <= wd_bit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      edge_irq_enable_mask_r <= '0;
    end else if (wr_edge_en) begin
      edge_irq_enable_mask_r <= wd_inputs;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      change_irq_enable_r <= 1'b0;
    end else if (wr_chg_en) begin
      change_irq_enable_r <= wd_bit;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      change_input_enable_mask_r <= '0;
    end else if (wr_chg_mask) begin
      change_input_enable_mask_r <= wd_inputs;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      counter_irq_enables_r <= '0;
    end else if (wr_cnt_en) begin
      counter_irq_enables_r <= wd_counters;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_irq_enables_r <= '0;
    end else if (wr_tmr_en) begin
      timer_irq_enables_r <= wd_timers;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      capture_irq_enables_r <= '0;
    end else if (wr_cap_en) begin
      capture_irq_enables_r <= wd_capture;
    end
  end

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      edge_irq_flags_r <= '0;
    end else begin
      edge_irq_flags_r <= edge_flags_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      change_irq_flag_r <= 1'b0;
    end else begin
      change_irq_flag_r <= change_flag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Unit clear pulses
  // ---------------------------------------------------------------
  // One-cycle pulses; idle cycles drive zero
  wire logic [N_COUNTERS-1:0] counter_clears_nxt = wr_cnt_clr ? wd_counters : '0;
  wire logic [N_TIMERS-1:0]   timer_clears_nxt   = wr_tmr_clr ? wd_timers : '0;
  wire logic [N_CAPTURE-1:0]  capture_clears_nxt = wr_cap_clr ? wd_capture : '0;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      counter_irq_clears_out <= '0;
    end else begin
      counter_irq_clears_out <= counter_clears_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      timer_irq_clears_out <= '0;
    end else begin
      timer_irq_clears_out <= timer_clears_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      capture_irq_clears_out <= '0;
    end else begin
      capture_irq_clears_out <= capture_clears_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [BIA_DW-1:0] rd_sel;
  // Write-only and unmapped offsets read as zero
  always_comb begin
    if (hit_global_en) begin
      rd_sel = BIA_DW'(global_en_r);
    end else if (hit_summary) begin
      rd_sel = summary_r;
    end else if (hit_edge_en) begin
      rd_sel = BIA_DW'(edge_irq_enable_mask_r);
    end else if (hit_edge_flags) begin
      rd_sel = BIA_DW'(edge_irq_flags_r);
    end else if (hit_chg_en) begin
      rd_sel = BIA_DW'(change_irq_enable_r);
    end else if (hit_chg_mask) begin
      rd_sel = BIA_DW'(change_input_enable_mask_r);
    end else if (hit_chg_flag) begin
      rd_sel = BIA_DW'(change_irq_flag_r);
    end else if (hit_cnt_en) begin
      rd_sel = BIA_DW'(counter_irq_enables_r);
    end else if (hit_cnt_flags) begin
      rd_sel = BIA_DW'(counter_irq_flags_in);
    end else if (hit_tmr_en) begin
      rd_sel = BIA_DW'(timer_irq_enables_r);
    end else if (hit_tmr_flags) begin
      rd_sel = BIA_DW'(timer_irq_flags_in);
    end else if (hit_cap_en) begin
      rd_sel = BIA_DW'(capture_irq_enables_r);
    end else if (hit_cap_flags) begin
      rd_sel = BIA_DW'(capture_irq_flags_in);
    end else if (hit_gate_stat) begin
      rd_sel = BIA_DW'(gate_r);
    end else begin
      rd_sel = BIA_RST_WORD;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_r <= BIA_RST_WORD;
    end else begin
      // Read data stands for one cycle only
      rdata_r <= reg_req_in.rd ? rd_sel : BIA_RST_WORD;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

/* bia_chk.sv */
`timescale 1ns/1ps
module bia_chk
  import bia_pkg::*;
#(
  parameter int unsigned N_COUNTERS = 16,
  parameter int unsigned N_TIMERS   = 2,
  parameter int unsigned N_COMPARE  = 2
) (
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire bia_req_t              reg_req_in,
  input wire logic [BIA_DW-1:0]     reg_rdata_out,
  input wire logic [N_COUNTERS-1:0] counter_irq_clears_out,
  input wire logic [N_TIMERS-1:0]   timer_irq_clears_out,
  input wire logic [N_COMPARE-1:0]  compare_irq_flags_in,
  input wire logic                  host_irq_out
);
  // ---------------------------------------------------------------
  // Decode and enable shadow
  // ---------------------------------------------------------------
  logic                  en_r;
  wire                   wr_en  = reg_req_in.wr && reg_req_in.addr == BIA_OFS_GLOBAL_EN;
  wire                   wr_gc  = reg_req_in.wr && reg_req_in.addr == BIA_OFS_GATE_CLR;
  wire                   wr_cc  = reg_req_in.wr && reg_req_in.addr == BIA_OFS_CNT_CLR;
  wire                   wr_tc  = reg_req_in.wr && reg_req_in.addr == BIA_OFS_TMR_CLR;
  wire                   rd_wo  = reg_req_in.rd && (reg_req_in.addr == BIA_OFS_EDGE_CLR ||
                                  reg_req_in.addr == BIA_OFS_GATE_CLR || reg_req_in.addr == BIA_OFS_CHG_CLR);
  wire [N_COUNTERS-1:0]  cnt_wd = reg_req_in.wdata[N_COUNTERS-1:0];
  wire [N_TIMERS-1:0]    tmr_wd = reg_req_in.wdata[N_TIMERS-1:0];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_r <= 1'b0;
    end else if (wr_en) begin
      en_r <= reg_req_in.wdata[0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_cnt_clr_pulse: assert property (wr_cc |=> counter_irq_clears_out == $past(cnt_wd))
    else $error("counter clear pulse wrong");
  a_cnt_clr_quiet: assert property (!wr_cc |=> counter_irq_clears_out == '0)
    else $error("counter clear pulse without write");
  a_tmr_clr_pulse: assert property (wr_tc |=> timer_irq_clears_out == $past(tmr_wd))
    else $error("timer clear pulse wrong");
  a_host_needs_en: assert property (host_irq_out |-> en_r)
    else $error("host line high while locked");
  a_host_holds: assert property (host_irq_out && !wr_gc && !wr_en |=> host_irq_out)
    else $error("host line dropped before re-arm");
  a_gate_clr_drop: assert property (wr_gc && reg_req_in.wdata[0] |=> !host_irq_out)
    else $error("host line not cleared by gate clear");
  a_wo_reads_zero: assert property (rd_wo |=> reg_rdata_out == '0)
    else $error("clear register reads nonzero");
  a_cmp_host_set: assert property ((en_r && (|compare_irq_flags_in) && !reg_req_in.wr)[*3] |=> host_irq_out)
    else $error("compare flag did not reach host");
  c_host_rise: cover property ($rose(host_irq_out));
  c_gate_clr: cover property (wr_gc && host_irq_out);
  c_cnt_clr: cover property (wr_cc);
endmodule

/* bia_unit_model.sv */
`timescale 1ns/1ps
module bia_unit_model #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] trig_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags_out
);
  logic [W-1:0] flags_r;
  assign flags_out = flags_r;
  // Flag holds until its own clear pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~clr_in) | trig_in;
    end
  end
endmodule

/* bia_tb_top.sv */
`timescale 1ns/1ps
module bia_tb_top
  import bia_pkg::*;
;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  bia_req_t    req      = '0;
  logic [15:0] iso      = '0;
  logic [15:0] cnt_trig = '0;
  logic [1:0]  tmr_trig = '0;
  logic [1:0]  cap_trig = '0;
  logic [1:0]  cmp      = '0;
  wire  [31:0] rdata;
  wire  [15:0] cnt_f, cnt_c;
  wire  [1:0]  tmr_f, tmr_c, cap_f, cap_c;
  wire         host;
  int          n_fail   = 0;
  int          n_checks = 0;
  int          cyc      = 0;
  always #12.5 clk_in = ~clk_in;
  bia_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata), .iso_in(iso),
    .counter_irq_flags_in(cnt_f), .timer_irq_flags_in(tmr_f), .capture_irq_flags_in(cap_f),
    .compare_irq_flags_in(cmp), .counter_irq_clears_out(cnt_c), .timer_irq_clears_out(tmr_c),
    .capture_irq_clears_out(cap_c), .host_irq_out(host));
  bia_unit_model #(.W(16)) u_cnt (.clk_in(clk_in), .rst_n_in(rst_n_in), .trig_in(cnt_trig), .clr_in(cnt_c),
    .flags_out(cnt_f));
  bia_unit_model #(.W(2)) u_tmr (.clk_in(clk_in), .rst_n_in(rst_n_in), .trig_in(tmr_trig), .clr_in(tmr_c),
    .flags_out(tmr_f));
  bia_unit_model #(.W(2)) u_cap (.clk_in(clk_in), .rst_n_in(rst_n_in), .trig_in(cap_trig), .clr_in(cap_c),
    .flags_out(cap_f));
  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_in);
    req <= '0;
    #1 chk(nm, rdata, exp);
  endtask
  task automatic wait_host(input logic exp);
    int i;
    #1;
    for (i = 0; i < 20 && host !== exp; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk("host", {31'h0, host}, {31'h0, exp});
  endtask
  task automatic rearm;
    wr(BIA_OFS_GATE_CLR, 32'h1);
    wait_host(1'b0);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdc("glob_en", BIA_OFS_GLOBAL_EN, 32'h0);
    rdc("chg_en", BIA_OFS_CHG_EN, 32'h0);
    rdc("chg_mask", BIA_OFS_CHG_MASK, 32'h0);
    rdc("summary", BIA_OFS_SUMMARY, 32'h0);
    rdc("unmapped", 12'hffc, 32'h0);
  endtask
  task automatic t_counter;
    wr(BIA_OFS_CNT_EN, 32'h8001);
    wr(BIA_OFS_TMR_EN, 32'h2);
    @(posedge clk_in) cnt_trig <= 16'h8000;
    @(posedge clk_in) cnt_trig <= '0;
    repeat (6) @(posedge clk_in);
    wait_host(1'b0);
    rdc("summary", BIA_OFS_SUMMARY, 32'h1 << BIA_SUM_COUNTER);
    wr(BIA_OFS_GLOBAL_EN, 32'h1);
    wait_host(1'b1);
    rdc("gate", BIA_OFS_GATE_STAT, 32'h1);
    rdc("cnt_en", BIA_OFS_CNT_EN, 32'h8001);
    rdc("cnt_flags", BIA_OFS_CNT_FLAGS, 32'h8000);
    @(posedge clk_in) tmr_trig <= 2'h2;
    @(posedge clk_in) tmr_trig <= '0;
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, (32'h1 << BIA_SUM_COUNTER) | (32'h1 << BIA_SUM_TIMER));
    wr(BIA_OFS_CNT_CLR, 32'h8000);
    wr(BIA_OFS_TMR_CLR, 32'h2);
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, 32'h0);
    rdc("tmr_flags", BIA_OFS_TMR_FLAGS, 32'h0);
    wait_host(1'b1);
    rearm;
  endtask
  task automatic t_edge;
    wr(BIA_OFS_EDGE_EN, 32'h8);
    rdc("edge_en", BIA_OFS_EDGE_EN, 32'h8);
    @(posedge clk_in) iso <= 16'h0028;
    wait_host(1'b1);
    rdc("edge_flags", BIA_OFS_EDGE_FLAGS, 32'h8);
    rdc("summary", BIA_OFS_SUMMARY, 32'h1 << BIA_SUM_EDGE);
    wr(BIA_OFS_EDGE_CLR, 32'h8);
    rdc("edge_clr", BIA_OFS_EDGE_CLR, 32'h0);
    rdc("edge_flags", BIA_OFS_EDGE_FLAGS, 32'h0);
    @(posedge clk_in) iso <= 16'h0020;
    repeat (5) @(posedge clk_in);
    rdc("edge_flags", BIA_OFS_EDGE_FLAGS, 32'h0);
    @(posedge clk_in) iso <= 16'h0028;
    repeat (5) @(posedge clk_in);
    rdc("edge_flags", BIA_OFS_EDGE_FLAGS, 32'h8);
    wr(BIA_OFS_EDGE_CLR, 32'h8);
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, 32'h0);
    rearm;
  endtask
  task automatic t_change;
    wr(BIA_OFS_CHG_MASK, 32'h2);
    wr(BIA_OFS_CHG_EN, 32'h1);
    @(posedge clk_in) iso <= 16'h0008;
    repeat (6) @(posedge clk_in);
    rdc("chg_flag", BIA_OFS_CHG_FLAG, 32'h0);
    @(posedge clk_in) iso <= 16'h000a;
    wait_host(1'b1);
    rdc("chg_flag", BIA_OFS_CHG_FLAG, 32'h1);
    rdc("summary", BIA_OFS_SUMMARY, 32'h1 << BIA_SUM_CHANGE);
    wr(BIA_OFS_CHG_CLR, 32'h1);
    rdc("chg_clr", BIA_OFS_CHG_CLR, 32'h0);
    rdc("chg_flag", BIA_OFS_CHG_FLAG, 32'h0);
    rearm;
  endtask
  task automatic t_compare;
    @(posedge clk_in) cmp <= 2'h2;
    wait_host(1'b1);
    rdc("summary", BIA_OFS_SUMMARY, 32'h1 << BIA_SUM_COMPARE);
    @(posedge clk_in) cmp <= 2'h0;
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, 32'h0);
    rearm;
    wr(BIA_OFS_CAP_EN, 32'h1);
    @(posedge clk_in) cap_trig <= 2'h1;
    @(posedge clk_in) cap_trig <= '0;
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, 32'h1 << BIA_SUM_COMPARE);
    rdc("cap_flags", BIA_OFS_CAP_FLAGS, 32'h1);
    wr(BIA_OFS_CAP_CLR, 32'h1);
    repeat (3) @(posedge clk_in);
    rdc("summary", BIA_OFS_SUMMARY, 32'h0);
    rearm;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_counter;
    t_edge;
    t_change;
    t_compare;
    results;
  end
endmodule
bind bia_top bia_chk #(.N_COUNTERS(N_COUNTERS), .N_TIMERS(N_TIMERS), .N_COMPARE(N_COMPARE)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
  .counter_irq_clears_out(counter_irq_clears_out), .timer_irq_clears_out(timer_irq_clears_out),
  .compare_irq_flags_in(compare_irq_flags_in), .host_irq_out(host_irq_out));
